// ---- logic/flag_instr_pkg.sv ----
package flag_instr_pkg;
   // flag positions inside flag_byte
   localparam logic [2:0] ADD_SPILL_POS = 3'h0;
   localparam logic [2:0] ALL_CLEAR_POS = 3'h1;
   localparam logic [2:0] MSB_COPY_POS = 3'h2;
   localparam logic [2:0] SIGNED_CARRY_POS = 3'h3;
   localparam logic [2:0] N_XOR_V_POS = 3'h4;
   localparam logic [2:0] NIBBLE_CARRY_POS = 3'h5;
   localparam logic [2:0] SAVED_BOOL_POS = 3'h6;
   localparam logic [2:0] MASTER_GATE_POS = 3'h7;
   localparam logic [7:0] FLAG_BYTE_RESET = 8'h00;
   // register port
   localparam int ADDR_W = 4;
   localparam logic [3:0] FLAG_BYTE_OFS = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h1;
   // cycle counts
   localparam int SLEEP_CLOCKS = 3;
   localparam logic [1:0] SLEEP_WAIT_LOAD = 2'(SLEEP_CLOCKS - 1);
   typedef enum logic [2:0] {
      OP_NOP,
      OP_COPY_BIT_TO_SAVED,
      OP_LOAD_BIT_FROM_SAVED,
      OP_FLAG_INDEX_ASSERT,
      OP_FLAG_INDEX_DEASSERT,
      OP_SLEEP,
      OP_WATCHDOG_KICK
   } instr_op_t;
   typedef enum logic {
      ST_RUN,
      ST_SLEEP_WAIT
   } exec_state_t;
endpackage

// ---- logic/status_flag_instr_unit.sv ----
`timescale 1ns/10ps
// Overview of operation
// RULE1 - copy_bit_to_saved puts selected register bit into saved_bool, one clock, nothing else.
// RULE2 - load_bit_from_saved writes saved_bool into selected destination bit; flags unchanged.
// RULE3 - open_master_gate sets master_gate in one clock, no other flag changes.
// RULE4 - shut_master_gate clears master_gate in one clock, no other flag changes.
// RULE5 - n_xor_v_flag set/clear forces it to 1 or 0 in one clock.
// RULE6 - signed_carry_out set/clear forces it to 1 or 0 in one clock.
// RULE7 - nibble_carry set/clear forces it to 1 or 0 in one clock.
// RULE8 - sleep takes three clocks, no flag change, then hands to sleep logic.
// RULE9 - watchdog_kick takes one clock, no flag change, signals the watchdog restart.
// RULE10 - other flag set/clear and indexed forms change only the addressed bit.
// RULE11 - no-operation takes one clock and changes no state.
module status_flag_instr_unit
   import flag_instr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic instr_valid,
   input wire instr_op_t instr_op,
   input wire logic [2:0] bit_sel,
   input wire logic [2:0] flag_idx,
   input wire logic [4:0] reg_idx,
   input wire logic [7:0] reg_value,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata_ff,
   output logic instr_ready_ff,
   output logic [7:0] flag_byte_ff,
   output logic reg_we_ff,
   output logic [4:0] reg_widx_ff,
   output logic [7:0] reg_wdata_ff,
   output logic sleep_enter_ff,
   output logic watchdog_kick_ff
);

   exec_state_t state_ff;
   logic [1:0] wait_cnt_ff;
   logic accept;
   logic flag_wr;
   logic [7:0] nxt_flag_byte;

   assign accept = instr_valid && instr_ready_ff;
   assign flag_wr = bus_wr && (bus_addr == FLAG_BYTE_OFS);

   // a same-cycle instruction edit lands on top of a software write
   always_comb begin
      nxt_flag_byte = flag_wr ? bus_wdata : flag_byte_ff;
      if (accept) begin
         unique case (instr_op)
            // RULE1 saved bit copy
            OP_COPY_BIT_TO_SAVED: nxt_flag_byte[SAVED_BOOL_POS] = reg_value[bit_sel];
            // RULE3 RULE5 RULE6 RULE7 RULE10 indexed set
            OP_FLAG_INDEX_ASSERT: nxt_flag_byte[flag_idx] = 1'b1;
            // RULE4 RULE5 RULE6 RULE7 RULE10 indexed clear
            OP_FLAG_INDEX_DEASSERT: nxt_flag_byte[flag_idx] = 1'b0;
            // RULE11 nop keeps everything
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_byte_ff <= FLAG_BYTE_RESET;
      end else begin
         flag_byte_ff <= nxt_flag_byte;
      end
   end

   // RULE2 bit load writeback
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_we_ff <= 1'b0;
         reg_widx_ff <= 5'h00;
         reg_wdata_ff <= 8'h00;
      end else begin
         reg_we_ff <= accept && (instr_op == OP_LOAD_BIT_FROM_SAVED);
         if (accept && (instr_op == OP_LOAD_BIT_FROM_SAVED)) begin
            reg_widx_ff <= reg_idx;
            reg_wdata_ff <= reg_value;
            reg_wdata_ff[bit_sel] <= flag_byte_ff[SAVED_BOOL_POS];
         end
      end
   end

   // RULE9 watchdog restart pulse
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         watchdog_kick_ff <= 1'b0;
      end else begin
         watchdog_kick_ff <= accept && (instr_op == OP_WATCHDOG_KICK);
      end
   end

   // RULE8 three-clock sleep occupancy
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_RUN;
         wait_cnt_ff <= 2'h0;
         instr_ready_ff <= 1'b1;
         sleep_enter_ff <= 1'b0;
      end else begin
         sleep_enter_ff <= 1'b0;
         unique case (state_ff)
            ST_RUN: begin
               if (accept && (instr_op == OP_SLEEP)) begin
                  state_ff <= ST_SLEEP_WAIT;
                  wait_cnt_ff <= SLEEP_WAIT_LOAD;
                  instr_ready_ff <= 1'b0;
               end
            end
            ST_SLEEP_WAIT: begin
               wait_cnt_ff <= wait_cnt_ff - 2'h1;
               if (wait_cnt_ff == 2'h1) begin
                  // control passes to the sleep controller here
                  state_ff <= ST_RUN;
                  instr_ready_ff <= 1'b1;
                  sleep_enter_ff <= 1'b1;
               end
            end
         endcase
      end
   end

   // unmapped offsets read as zero
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_rdata_ff <= 8'h00;
      end else if (bus_rd) begin
         unique case (bus_addr)
            FLAG_BYTE_OFS: bus_rdata_ff <= flag_byte_ff;
            STATUS_OFS: bus_rdata_ff <= {7'h00, state_ff == ST_SLEEP_WAIT};
            default: bus_rdata_ff <= 8'h00;
         endcase
      end else begin
         bus_rdata_ff <= 8'h00;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   saved_bit_copy_a: assert property ( // RULE1
      accept && instr_op == OP_COPY_BIT_TO_SAVED && !bus_wr |=>
      flag_byte_ff[SAVED_BOOL_POS] == $past(reg_value[bit_sel]) &&
      (flag_byte_ff & 8'hBF) == ($past(flag_byte_ff) & 8'hBF))
      else $error("saved bit copy wrong");

   bit_load_write_a: assert property ( // RULE2
      accept && instr_op == OP_LOAD_BIT_FROM_SAVED && !bus_wr |=>
      reg_we_ff && reg_wdata_ff[$past(bit_sel)] == $past(flag_byte_ff[SAVED_BOOL_POS]) &&
      reg_widx_ff == $past(reg_idx) && flag_byte_ff == $past(flag_byte_ff))
      else $error("bit load writeback wrong");

   gate_open_a: assert property ( // RULE3
      accept && instr_op == OP_FLAG_INDEX_ASSERT && flag_idx == MASTER_GATE_POS && !bus_wr |=>
      flag_byte_ff == ($past(flag_byte_ff) | 8'h80))
      else $error("master gate not opened");

   gate_shut_a: assert property ( // RULE4
      accept && instr_op == OP_FLAG_INDEX_DEASSERT && flag_idx == MASTER_GATE_POS && !bus_wr |=>
      flag_byte_ff == ($past(flag_byte_ff) & 8'h7F))
      else $error("master gate not shut");

   indexed_set_a: assert property ( // RULE10
      accept && instr_op == OP_FLAG_INDEX_ASSERT && !bus_wr |=>
      flag_byte_ff == ($past(flag_byte_ff) | (8'h01 << $past(flag_idx))))
      else $error("indexed set wrong");

   indexed_clear_a: assert property ( // RULE10
      accept && instr_op == OP_FLAG_INDEX_DEASSERT && !bus_wr |=>
      flag_byte_ff == ($past(flag_byte_ff) & ~(8'h01 << $past(flag_idx))))
      else $error("indexed clear wrong");

   sleep_length_a: assert property ( // RULE8
      accept && instr_op == OP_SLEEP |=>
      !instr_ready_ff && !sleep_enter_ff ##1 !instr_ready_ff && !sleep_enter_ff
      ##1 instr_ready_ff && sleep_enter_ff)
      else $error("sleep length wrong");

   sleep_flags_a: assert property ( // RULE8
      accept && instr_op == OP_SLEEP && !bus_wr |=> flag_byte_ff == $past(flag_byte_ff))
      else $error("sleep changed flags");

   kick_pulse_a: assert property ( // RULE9
      accept && instr_op == OP_WATCHDOG_KICK && !bus_wr |=>
      watchdog_kick_ff && flag_byte_ff == $past(flag_byte_ff) ##1 !watchdog_kick_ff || instr_valid)
      else $error("watchdog kick wrong");

   nop_quiet_a: assert property ( // RULE11
      accept && instr_op == OP_NOP && !bus_wr |=>
      flag_byte_ff == $past(flag_byte_ff) && !reg_we_ff && !watchdog_kick_ff && instr_ready_ff)
      else $error("nop changed state");

   sign_test_a: assert property ( // RULE5
      accept && (instr_op == OP_FLAG_INDEX_ASSERT || instr_op == OP_FLAG_INDEX_DEASSERT) &&
      flag_idx == N_XOR_V_POS && !bus_wr |=>
      flag_byte_ff[N_XOR_V_POS] == ($past(instr_op) == OP_FLAG_INDEX_ASSERT) &&
      ((flag_byte_ff ^ $past(flag_byte_ff)) & ~(8'h01 << N_XOR_V_POS)) == 8'h00)
      else $error("sign test flag edit wrong");

   signed_carry_a: assert property ( // RULE6
      accept && (instr_op == OP_FLAG_INDEX_ASSERT || instr_op == OP_FLAG_INDEX_DEASSERT) &&
      flag_idx == SIGNED_CARRY_POS && !bus_wr |=>
      flag_byte_ff[SIGNED_CARRY_POS] == ($past(instr_op) == OP_FLAG_INDEX_ASSERT) &&
      ((flag_byte_ff ^ $past(flag_byte_ff)) & ~(8'h01 << SIGNED_CARRY_POS)) == 8'h00)
      else $error("signed carry flag edit wrong");

   nibble_carry_a: assert property ( // RULE7
      accept && (instr_op == OP_FLAG_INDEX_ASSERT || instr_op == OP_FLAG_INDEX_DEASSERT) &&
      flag_idx == NIBBLE_CARRY_POS && !bus_wr |=>
      flag_byte_ff[NIBBLE_CARRY_POS] == ($past(instr_op) == OP_FLAG_INDEX_ASSERT) &&
      ((flag_byte_ff ^ $past(flag_byte_ff)) & ~(8'h01 << NIBBLE_CARRY_POS)) == 8'h00)
      else $error("nibble carry flag edit wrong");

   // software write alone must land whole
   flag_write_a: assert property (
      flag_wr && !accept |=> flag_byte_ff == $past(bus_wdata))
      else $error("flag byte write lost");

   read_data_a: assert property (
      bus_rd && bus_addr == FLAG_BYTE_OFS |=> bus_rdata_ff == $past(flag_byte_ff))
      else $error("flag byte read wrong");

   // read data stands for one cycle only
   read_idle_a: assert property (
      !bus_rd |=> bus_rdata_ff == 8'h00)
      else $error("read data not cleared");

endmodule

// ---- dv/decode_model.sv ----
`timescale 1ns/10ps
module decode_model
   import flag_instr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic instr_ready_ff,
   output logic instr_valid,
   output instr_op_t instr_op,
   output logic [2:0] bit_sel,
   output logic [2:0] flag_idx,
   output logic [4:0] reg_idx,
   output logic [7:0] reg_value
);
   initial begin
      instr_valid = 1'b0;
      instr_op = OP_NOP;
      {bit_sel, flag_idx, reg_idx, reg_value} = '0;
   end
   // the offer stays whole until the core takes it
   task automatic issue(input instr_op_t op, input logic [2:0] b, input logic [2:0] f, input logic [7:0] v);
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr_op <= op;
      bit_sel <= b;
      flag_idx <= f;
      reg_idx <= {2'b10, b};
      reg_value <= v;
      @(posedge sys_clk);
      while (instr_ready_ff !== 1'b1) @(posedge sys_clk);
      instr_valid <= 1'b0;
      #1;
   endtask
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/10ps
module tb
   import flag_instr_pkg::*;
;
   logic sys_clk = 0, reset_n = 0, bus_wr = 0, bus_rd = 0, instr_valid, instr_ready_ff, reg_we_ff;
   logic sleep_enter_ff, watchdog_kick_ff;
   logic [3:0] bus_addr = 0;
   logic [2:0] bit_sel, flag_idx;
   logic [4:0] reg_idx, reg_widx_ff;
   logic [7:0] bus_wdata = 0, exp_f = 0, reg_value, bus_rdata_ff, flag_byte_ff, reg_wdata_ff;
   instr_op_t instr_op;
   int miscompares = 0, cmp_count = 0, cyc = 0;
   decode_model dec_u (.sys_clk, .instr_ready_ff, .instr_valid, .instr_op, .bit_sel, .flag_idx, .reg_idx,
      .reg_value);
   status_flag_instr_unit dut_u (.sys_clk, .reset_n, .instr_valid, .instr_op, .bit_sel, .flag_idx, .reg_idx,
      .reg_value, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata_ff, .instr_ready_ff, .flag_byte_ff,
      .reg_we_ff, .reg_widx_ff, .reg_wdata_ff, .sleep_enter_ff, .watchdog_kick_ff);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic bus_w(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
   endtask
   task automatic bus_r(input logic [3:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1 chk(bus_rdata_ff, e);
   endtask
   task automatic t_flags();
      for (int i = 0; i < 16; i++) begin
         dec_u.issue(i < 8 ? OP_FLAG_INDEX_ASSERT : OP_FLAG_INDEX_DEASSERT, 3'h0, 3'(i), 8'h00);
         exp_f[i % 8] = (i < 8);
         chk(flag_byte_ff, exp_f);
      end
      $display("flag set and clear done");
   endtask
   task automatic t_bits();
      dec_u.issue(OP_COPY_BIT_TO_SAVED, 3'h2, 3'h0, 8'h04);
      chk(flag_byte_ff, 8'h40);
      dec_u.issue(OP_COPY_BIT_TO_SAVED, 3'h1, 3'h0, 8'h04);
      chk(flag_byte_ff, 8'h00);
      dec_u.issue(OP_FLAG_INDEX_ASSERT, 3'h0, SAVED_BOOL_POS, 8'h00);
      dec_u.issue(OP_LOAD_BIT_FROM_SAVED, 3'h3, 3'h0, 8'h00);
      chk(flag_byte_ff, 8'h40);
      chk({reg_we_ff, 2'h0, reg_widx_ff}, 8'h93);
      chk(reg_wdata_ff, 8'h08);
      $display("bit copy and load done");
   endtask
   task automatic t_misc();
      dec_u.issue(OP_SLEEP, 3'h0, 3'h0, 8'h00);
      chk({instr_ready_ff, sleep_enter_ff, flag_byte_ff[5:0]}, 8'h00);
      @(posedge sys_clk);
      #1 chk({instr_ready_ff, sleep_enter_ff, flag_byte_ff[5:0]}, 8'h00);
      @(posedge sys_clk);
      #1 chk({instr_ready_ff, sleep_enter_ff, flag_byte_ff[5:0]}, 8'hc0);
      dec_u.issue(OP_WATCHDOG_KICK, 3'h0, 3'h0, 8'h00);
      chk({watchdog_kick_ff, 1'b0, flag_byte_ff[5:0]}, 8'h80);
      dec_u.issue(OP_NOP, 3'h0, 3'h0, 8'h00);
      chk({reg_we_ff, sleep_enter_ff, watchdog_kick_ff, 5'h00}, 8'h00);
      chk(flag_byte_ff, 8'h40);
      $display("sleep, kick and idle done");
   endtask
   task automatic t_bus();
      bus_w(FLAG_BYTE_OFS, 8'h5a);
      bus_r(FLAG_BYTE_OFS, 8'h5a);
      bus_w(4'h9, 8'hff);
      bus_r(FLAG_BYTE_OFS, 8'h5a);
      bus_r(4'h9, 8'h00);
      dec_u.issue(OP_SLEEP, 3'h0, 3'h0, 8'h00);
      bus_r(STATUS_OFS, 8'h01);
      bus_r(STATUS_OFS, 8'h00);
      $display("register port done");
   endtask
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      #1 chk({instr_ready_ff, flag_byte_ff[6:0]}, 8'h80);
      t_flags();
      t_bits();
      t_misc();
      t_bus();
      test_done();
   end
endmodule
